// ### rtl/pmb_pkg.sv
package pmb_pkg;

    // host-side word offsets inside the first base address region
    localparam logic [7:0] PMB_OFF_OUT_MBOX   = 8'h0c;
    localparam logic [7:0] PMB_OFF_IN_MBOX    = 8'h1c;
    localparam logic [7:0] PMB_OFF_FILL_FLAGS = 8'h34;
    localparam logic [7:0] PMB_OFF_IRQ_CSR    = 8'h38;
    localparam logic [7:0] PMB_OFF_SOFT_RST   = 8'h3c;
    localparam logic [7:0] PMB_OFF_PT_CONFIG  = 8'h60;

    // reset values
    localparam logic [31:0] PMB_RST_MBOX       = 32'h0000_0000;
    localparam logic [31:0] PMB_RST_FILL_FLAGS = 32'h0000_0000;
    localparam logic [31:0] PMB_RST_IRQ_CSR    = 32'h0000_0c0c;
    localparam logic [31:0] PMB_RST_PT_CONFIG  = 32'h8080_8080;

    // fill flag register field positions (low bit of each nibble)
    localparam int PMB_FILL_IN_LSB  = 28;
    localparam int PMB_FILL_OUT_LSB = 12;

    // interrupt control/status field positions
    localparam int PMB_IRQ_ASSERTED = 23;
    localparam int PMB_IRQ_ADDON    = 22;
    localparam int PMB_IRQ_IN_FLAG  = 17;
    localparam int PMB_IRQ_OUT_FLAG = 16;
    localparam int PMB_IRQ_ADDON_EN = 13;
    localparam int PMB_IRQ_IN_EN    = 12;
    localparam int PMB_IRQ_IN_SEL   = 8;
    localparam int PMB_IRQ_OUT_EN   = 4;
    localparam int PMB_IRQ_OUT_SEL  = 0;
    localparam int PMB_IRQ_HARD_HI  = 10;
    localparam int PMB_IRQ_HARD_LO  = 2;
    localparam logic [1:0] PMB_IRQ_HARD_VAL = 2'h3;

    // soft reset control field positions
    localparam int PMB_RST_FLAG_CLR  = 27;
    localparam int PMB_RST_ADDON_PIN = 24;

    // host register request, one per access
    typedef struct packed {
        logic        req;
        logic        we;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pmb_host_req_t;

    // local-side mailbox activity
    typedef struct packed {
        logic        wr;       // write into incoming mailbox
        logic [3:0]  wr_be;
        logic [31:0] wdata;
        logic        rd;       // read of outgoing mailbox
        logic [3:0]  rd_be;
        logic        ext_ld;   // external load of byte 3
        logic [7:0]  ext_byte;
    } pmb_loc_req_t;

    // local interrupt control as set up on the local side
    typedef struct packed {
        logic       wr_en;     // host writes outgoing mailbox
        logic [1:0] wr_sel;
        logic       rd_en;     // host reads incoming mailbox
        logic [1:0] rd_sel;
    } pmb_loc_irq_cfg_t;

    // whole state of the register block
    typedef struct packed {
        logic [31:0] out_mbox;
        logic [31:0] in_mbox;
        logic [3:0]  out_full;
        logic [3:0]  in_full;
        logic        in_flag;
        logic        out_flag;
        logic        addon_en;
        logic        in_en;
        logic [1:0]  in_sel;
        logic        out_en;
        logic [1:0]  out_sel;
        logic        addon_rst;
        logic [31:0] pt_config;
        logic [31:0] rdata;
        logic        ack;
        logic        host_irq;
        logic        loc_irq;
    } pmb_state_t;

endpackage : pmb_pkg

// ### rtl/pmb_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

// three-stage pin synchroniser; output moves only when stages two and three agree
module pmb_pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    output var  logic level_out
);
    import pmb_pkg::*;

    logic [2:0] stage_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage_q   <= {3{RESET_LEVEL}};
            level_out <= RESET_LEVEL;
        end else begin
            stage_q <= {stage_q[1:0], pin_in};
            if (stage_q[1] == stage_q[2]) begin
                level_out <= stage_q[2];
            end
        end
    end

endmodule : pmb_pin_sync

`default_nettype wire

// ### rtl/pmb_mailbox_regs.sv
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// RULE_01: six word registers in base region
// RULE_02: fixed offsets 0c,1c,34,38,3c,60
// RULE_03: no simultaneous access from both sides
// RULE_04: host avoids unmapped offsets
// RULE_05: outgoing mailbox byte/half/word read-write
// RULE_06: host outgoing write may raise local interrupt
// RULE_07: outgoing read changes no flag
// RULE_08: incoming mailbox read-only, any width
// RULE_09: host incoming read may raise local interrupt
// RULE_10: byte 3 loadable by external hardware
// RULE_11: per-byte fill flag, set write, clear read
// RULE_12: incoming flags at bits 31:28
// RULE_13: outgoing flags at bits 15:12
// RULE_14: fill flags read-only, zero, shared view
// RULE_15: three host interrupt sources
// RULE_16: irq csr resets 0c0c, write-one acknowledges
// RULE_17: bits 17,16 write-one clear
// RULE_18: bit 12 with byte select 9:8
// RULE_19: bit 4 with byte select 1:0
// RULE_20: bit 23 ORs flags, drives host line
// RULE_21: simultaneous set and clear keeps full
module pmb_mailbox_regs
    import pmb_pkg::*;
(
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    input  wire pmb_host_req_t    host_req_in,
    output var  logic [31:0]      host_rdata_out,
    output var  logic             host_ack_out,
    output var  logic             host_irq_out,
    input  wire pmb_loc_req_t     loc_req_in,
    input  wire pmb_loc_irq_cfg_t loc_irq_cfg_in,
    input  wire logic             loc_irq_clr_in,
    input  wire logic             local_interrupt_request_n_in,
    output var  logic [31:0]      local_incoming_mailbox_view_out,
    output var  logic [31:0]      local_outgoing_mailbox_view_out,
    output var  logic [31:0]      local_fill_flags_view_out,
    output var  logic             loc_irq_out,
    output var  logic             addon_reset_out,
    output var  logic [31:0]      passthrough_region_config_out
);

    pmb_state_t st_q;
    pmb_state_t st_d;
    logic       addon_pin_level;   // synchronised pin, low means request

    // merge new bytes into a word under byte enables
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  be);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // two-bit byte select to one-hot lane mask
    function automatic logic [3:0] byte_mask(input logic [1:0] sel);
        logic [3:0] m;
        m = 4'h0;
        m[sel] = 1'b1;
        return m;
    endfunction : byte_mask

    // fill-flag word as both sides see it
    function automatic logic [31:0] fill_word(input logic [3:0] in_f,
                                              input logic [3:0] out_f);
        logic [31:0] w;
        w = PMB_RST_FILL_FLAGS;
        w[PMB_FILL_IN_LSB +: 4]  = in_f;
        w[PMB_FILL_OUT_LSB +: 4] = out_f;
        return w;
    endfunction : fill_word

    // the pin is asynchronous to the bus clock
    pmb_pin_sync #(
        .RESET_LEVEL (1'b1)
    ) u_addon_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .pin_in     (local_interrupt_request_n_in),
        .level_out  (addon_pin_level)
    );

    logic        addon_req;
    logic        irq_any;
    logic [31:0] irq_word;
    logic        hit_out_mbox;
    logic        hit_in_mbox;
    logic        hit_fill;
    logic        hit_irq;
    logic        hit_rst;
    logic        hit_pt;
    logic        host_wr;
    logic        host_rd;
    logic [3:0]  in_set;
    logic [3:0]  out_set;
    logic [3:0]  in_clr;
    logic [3:0]  out_clr;
    logic        flag_clr_all;
    logic        in_evt;
    logic        out_evt;
    logic        loc_evt;

    // address decode of the six word locations
    always_comb begin
        host_wr      = host_req_in.req & host_req_in.we;
        host_rd      = host_req_in.req & ~host_req_in.we;
        hit_out_mbox = (host_req_in.addr == PMB_OFF_OUT_MBOX);   // [RULE_01] [RULE_02]
        hit_in_mbox  = (host_req_in.addr == PMB_OFF_IN_MBOX);    // [RULE_02]
        hit_fill     = (host_req_in.addr == PMB_OFF_FILL_FLAGS); // [RULE_02]
        hit_irq      = (host_req_in.addr == PMB_OFF_IRQ_CSR);    // [RULE_02]
        hit_rst      = (host_req_in.addr == PMB_OFF_SOFT_RST);   // [RULE_02]
        hit_pt       = (host_req_in.addr == PMB_OFF_PT_CONFIG);  // [RULE_02]
    end

    // interrupt status word, built from current state
    always_comb begin
        addon_req = ~addon_pin_level;                        // [RULE_15]
        irq_any   = st_q.in_flag | st_q.out_flag
                    | (addon_req & st_q.addon_en);           // [RULE_20]
        irq_word  = 32'h0000_0000;
        irq_word[PMB_IRQ_ASSERTED]     = irq_any;            // [RULE_20]
        irq_word[PMB_IRQ_ADDON]        = addon_req;
        irq_word[PMB_IRQ_IN_FLAG]      = st_q.in_flag;
        irq_word[PMB_IRQ_OUT_FLAG]     = st_q.out_flag;
        irq_word[PMB_IRQ_ADDON_EN]     = st_q.addon_en;
        irq_word[PMB_IRQ_IN_EN]        = st_q.in_en;
        irq_word[PMB_IRQ_HARD_HI +: 2] = PMB_IRQ_HARD_VAL;  // [RULE_16]
        irq_word[PMB_IRQ_IN_SEL +: 2]  = st_q.in_sel;
        irq_word[PMB_IRQ_OUT_EN]       = st_q.out_en;
        irq_word[PMB_IRQ_HARD_LO +: 2] = PMB_IRQ_HARD_VAL;  // [RULE_16]
        irq_word[PMB_IRQ_OUT_SEL +: 2] = st_q.out_sel;
    end

    // fill-flag events from both sides
    always_comb begin
        out_set = (host_wr && hit_out_mbox) ? host_req_in.be : 4'h0;  // [RULE_11]
        out_clr = loc_req_in.rd ? loc_req_in.rd_be : 4'h0;            // [RULE_11]
        in_set  = loc_req_in.wr ? loc_req_in.wr_be : 4'h0;            // [RULE_11]
        in_set[3] = in_set[3] | loc_req_in.ext_ld;                    // [RULE_10]
        in_clr  = (host_rd && hit_in_mbox) ? host_req_in.be : 4'h0;   // [RULE_11]
        flag_clr_all = host_wr && hit_rst && host_req_in.be[3]
                       && host_req_in.wdata[PMB_RST_FLAG_CLR];
        // mailbox interrupts fire only on the selected byte
        in_evt  = st_q.in_en && ((in_set & byte_mask(st_q.in_sel)) != 4'h0);     // [RULE_18]
        out_evt = st_q.out_en && ((out_clr & byte_mask(st_q.out_sel)) != 4'h0); // [RULE_19]
        // local-side interrupt from host mailbox traffic
        loc_evt = (loc_irq_cfg_in.wr_en
                   && ((out_set & byte_mask(loc_irq_cfg_in.wr_sel)) != 4'h0))    // [RULE_06]
                | (loc_irq_cfg_in.rd_en
                   && ((in_clr & byte_mask(loc_irq_cfg_in.rd_sel)) != 4'h0));    // [RULE_09]
    end

    // next-state of every register
    always_comb begin
        st_d     = st_q;
        st_d.ack = host_req_in.req;

        // outgoing mailbox: host writes any lane width
        if (host_wr && hit_out_mbox) begin
            st_d.out_mbox = lane_merge(st_q.out_mbox, host_req_in.wdata,
                                       host_req_in.be);             // [RULE_05]
        end

        // incoming mailbox: written only from the local side
        if (loc_req_in.wr) begin
            st_d.in_mbox = lane_merge(st_q.in_mbox, loc_req_in.wdata,
                                      loc_req_in.wr_be);            // [RULE_08]
        end
        if (loc_req_in.ext_ld) begin
            st_d.in_mbox[31:24] = loc_req_in.ext_byte;              // [RULE_10]
        end

        // a set in the same cycle as a clear leaves the byte full
        if (flag_clr_all) begin
            st_d.out_full = out_set;
            st_d.in_full  = in_set;
        end else begin
            st_d.out_full = (st_q.out_full & ~out_clr) | out_set;   // [RULE_11] [RULE_21]
            st_d.in_full  = (st_q.in_full & ~in_clr) | in_set;      // [RULE_11] [RULE_21]
        end

        // interrupt control fields, per byte lane
        if (host_wr && hit_irq) begin
            if (host_req_in.be[2]) begin
                if (host_req_in.wdata[PMB_IRQ_IN_FLAG]) begin
                    st_d.in_flag = 1'b0;                            // [RULE_17]
                end
                if (host_req_in.wdata[PMB_IRQ_OUT_FLAG]) begin
                    st_d.out_flag = 1'b0;                           // [RULE_17]
                end
            end
            if (host_req_in.be[1]) begin
                st_d.addon_en = host_req_in.wdata[PMB_IRQ_ADDON_EN];
                st_d.in_en    = host_req_in.wdata[PMB_IRQ_IN_EN];
                st_d.in_sel   = host_req_in.wdata[PMB_IRQ_IN_SEL +: 2];
            end
            if (host_req_in.be[0]) begin
                st_d.out_en  = host_req_in.wdata[PMB_IRQ_OUT_EN];
                st_d.out_sel = host_req_in.wdata[PMB_IRQ_OUT_SEL +: 2];
            end
        end
        // hardware set wins over an acknowledge in the same cycle
        if (in_evt) begin
            st_d.in_flag = 1'b1;                                    // [RULE_15] [RULE_18]
        end
        if (out_evt) begin
            st_d.out_flag = 1'b1;                                   // [RULE_15] [RULE_19]
        end

        // soft reset control: only the add-on reset bit is stored
        if (host_wr && hit_rst && host_req_in.be[3]) begin
            st_d.addon_rst = host_req_in.wdata[PMB_RST_ADDON_PIN];
        end

        // pass-through configuration is stored for the local side
        if (host_wr && hit_pt) begin
            st_d.pt_config = lane_merge(st_q.pt_config, host_req_in.wdata,
                                        host_req_in.be);
        end

        // local interrupt: sticky, set beats the local clear
        if (loc_irq_clr_in) begin
            st_d.loc_irq = 1'b0;
        end
        if (loc_evt) begin
            st_d.loc_irq = 1'b1;                                    // [RULE_06] [RULE_09]
        end

        // read data; host read of outgoing mailbox touches no flag
        st_d.rdata = 32'h0000_0000;
        if (host_rd) begin
            unique case (1'b1)
                hit_out_mbox: st_d.rdata = st_q.out_mbox;           // [RULE_05] [RULE_07]
                hit_in_mbox:  st_d.rdata = st_q.in_mbox;            // [RULE_08]
                hit_fill:     st_d.rdata = fill_word(st_q.in_full,
                                                     st_q.out_full); // [RULE_12] [RULE_13] [RULE_14]
                hit_irq:      st_d.rdata = irq_word;                // [RULE_16]
                hit_rst: begin
                    st_d.rdata[PMB_RST_ADDON_PIN] = st_q.addon_rst;
                end
                hit_pt:       st_d.rdata = st_q.pt_config;
                default:      st_d.rdata = 32'h0000_0000;           // unmapped offset
            endcase
        end

        // host line follows the asserted bit
        st_d.host_irq = irq_any;                                    // [RULE_20]
    end

    // single register stage for all state
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q           <= '0;
            st_q.out_mbox  <= PMB_RST_MBOX;
            st_q.in_mbox   <= PMB_RST_MBOX;
            st_q.in_sel    <= PMB_RST_IRQ_CSR[PMB_IRQ_IN_SEL +: 2];  // [RULE_16]
            st_q.out_sel   <= PMB_RST_IRQ_CSR[PMB_IRQ_OUT_SEL +: 2]; // [RULE_16]
            st_q.pt_config <= PMB_RST_PT_CONFIG;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs come straight from the state flops
    always_comb begin
        host_rdata_out                  = st_q.rdata;
        host_ack_out                    = st_q.ack;
        host_irq_out                    = st_q.host_irq;
        local_incoming_mailbox_view_out = st_q.out_mbox;
        local_outgoing_mailbox_view_out = st_q.in_mbox;
        local_fill_flags_view_out       = fill_word(st_q.in_full,
                                                    st_q.out_full); // [RULE_14]
        loc_irq_out                     = st_q.loc_irq;
        addon_reset_out                 = st_q.addon_rst;
        passthrough_region_config_out   = st_q.pt_config;
    end

endmodule : pmb_mailbox_regs

`default_nettype wire

// ### tb/pmb_mailbox_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none

// watches the host port and the local views of the mailbox block
module pmb_mailbox_checker
    import pmb_pkg::*;
(
    input wire logic          clk_sys_in,
    input wire logic          rst_n_in,
    input wire pmb_host_req_t host_req_in,
    input wire logic [31:0]   host_rdata_out,
    input wire logic          host_ack_out,
    input wire pmb_loc_req_t  loc_req_in,
    input wire logic [31:0]   local_incoming_mailbox_view_out,
    input wire logic [31:0]   local_outgoing_mailbox_view_out,
    input wire logic [31:0]   local_fill_flags_view_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    // host steps; local side kept quiet where flags must not move
    sequence s_out_wr;
        host_req_in.req && host_req_in.we && host_req_in.addr == PMB_OFF_OUT_MBOX;
    endsequence
    sequence s_in_rd;
        host_req_in.req && !host_req_in.we && host_req_in.addr == PMB_OFF_IN_MBOX
            && !loc_req_in.wr && !loc_req_in.ext_ld;
    endsequence
    sequence s_quiet_acc(logic w, logic [7:0] a);
        host_req_in.req && host_req_in.we == w && host_req_in.addr == a
            && !loc_req_in.wr && !loc_req_in.rd && !loc_req_in.ext_ld;
    endsequence

    a_ack_one_cycle: assert property (host_req_in.req |=> host_ack_out)
        else $error("no answer one cycle after a request");
    a_ack_needs_req: assert property (host_ack_out |-> $past(host_req_in.req))
        else $error("answer without a request");
    a_out_fill_set: assert property (s_out_wr |=>
        (local_fill_flags_view_out[15:12] & $past(host_req_in.be)) == $past(host_req_in.be))
        else $error("outgoing byte written but not marked full");
    a_out_view_data: assert property (s_out_wr ##0 host_req_in.be == 4'hf |=>
        local_incoming_mailbox_view_out == $past(host_req_in.wdata))
        else $error("outgoing word not seen on the local side");
    a_in_fill_set: assert property (loc_req_in.wr |=>
        (local_fill_flags_view_out[31:28] & $past(loc_req_in.wr_be)) == $past(loc_req_in.wr_be))
        else $error("incoming byte written but not marked full");
    a_in_fill_clear: assert property (s_in_rd |=>
        (local_fill_flags_view_out[31:28] & $past(host_req_in.be)) == 4'h0)
        else $error("incoming byte read but still full");
    a_in_rdata_view: assert property (s_in_rd ##0 host_req_in.be == 4'hf |=>
        host_rdata_out == local_outgoing_mailbox_view_out)
        else $error("incoming read data differs from mailbox");
    a_out_rd_quiet: assert property (s_quiet_acc(1'b0, PMB_OFF_OUT_MBOX) |=>
        $stable(local_fill_flags_view_out))
        else $error("outgoing read changed fill flags");
    a_ro_write_kept: assert property (s_quiet_acc(1'b1, PMB_OFF_IN_MBOX) or
        s_quiet_acc(1'b1, PMB_OFF_FILL_FLAGS) |=> $stable(local_fill_flags_view_out)
        && $stable(local_outgoing_mailbox_view_out))
        else $error("host write changed a read-only place");
    a_ext_load_byte: assert property (loc_req_in.ext_ld |=>
        local_outgoing_mailbox_view_out[31:24] == $past(loc_req_in.ext_byte)
        && local_fill_flags_view_out[31])
        else $error("external byte load lost");
endmodule : pmb_mailbox_checker

bind pmb_mailbox_regs pmb_mailbox_checker i_pmb_mailbox_checker (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .host_req_in(host_req_in),
    .host_rdata_out(host_rdata_out), .host_ack_out(host_ack_out), .loc_req_in(loc_req_in),
    .local_incoming_mailbox_view_out(local_incoming_mailbox_view_out),
    .local_outgoing_mailbox_view_out(local_outgoing_mailbox_view_out),
    .local_fill_flags_view_out(local_fill_flags_view_out));

`default_nettype wire

// ### tb/pmb_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// host bus master: one access at a time, each a single-cycle request
module pmb_host_model
    import pmb_pkg::*;
(
    input  wire logic          clk_sys_in,
    input  wire logic          host_ack_in,
    output var  pmb_host_req_t host_req_out
);
    initial host_req_out = '0;

    // waits for the answer before the next request, so no overlap
    task automatic access(input logic we, input logic [7:0] addr, input logic [3:0] be,
                          input logic [31:0] wdata, output bit ok);
        int n;
        @(posedge clk_sys_in);
        host_req_out <= '{req: 1'b1, we: we, addr: addr, be: be, wdata: wdata};
        @(posedge clk_sys_in);
        // released lines show the inverse, never a stale copy
        host_req_out <= '{req: 1'b0, we: ~we, addr: ~addr, be: ~be, wdata: ~wdata};
        ok = 1'b0;
        for (n = 0; n < 8 && !ok; n++) begin
            @(posedge clk_sys_in);
            ok = (host_ack_in === 1'b1);
        end
    endtask : access
endmodule : pmb_host_model

`default_nettype wire

// ### tb/pmb_mailbox_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module pmb_mailbox_regs_tb_top;
    import pmb_pkg::*;
    logic             clk;
    logic             rst_n;
    pmb_host_req_t    hreq;
    logic [31:0]      rdata;
    logic             ack;
    logic             hirq;
    pmb_loc_req_t     loc;
    pmb_loc_irq_cfg_t cfg;
    logic             clr;
    logic             lirq;
    logic [31:0]      om, im, c, r;
    logic [32:0]      note_q[$];
    logic [32:0]      note;
    int               bad_count, cmp_count, i;
    logic [31:0]      seed = 32'h0000_79f5;
    logic             pin_n, arst;   // add-on request pin, add-on reset seen

    pmb_host_model i_pmb_host_model (.clk_sys_in(clk), .host_ack_in(ack), .host_req_out(hreq));
    pmb_mailbox_regs i_pmb_mailbox_regs (.clk_sys_in(clk), .rst_n_in(rst_n),
        .host_req_in(hreq), .host_rdata_out(rdata), .host_ack_out(ack), .host_irq_out(hirq),
        .loc_req_in(loc), .loc_irq_cfg_in(cfg), .loc_irq_clr_in(clr),
        .local_interrupt_request_n_in(pin_n), .local_incoming_mailbox_view_out(),
        .local_outgoing_mailbox_view_out(), .local_fill_flags_view_out(),
        .loc_irq_out(lirq), .addon_reset_out(arst), .passthrough_region_config_out());

    always #5 clk = ~clk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("counts: compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // notes the expected answer, then has the host model make the access
    task automatic acc(input logic we, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d);
        bit ok;
        note_q.push_back({~we, we ? 32'h0 : d});
        i_pmb_host_model.access(we, a, be, we ? d : xs(), ok);
        if (!ok) begin
            bad_count++;
            stop_test();
        end
    endtask : acc

    // one-cycle local strobe; idle data lines carry the inverse afterwards
    task automatic lp(input pmb_loc_req_t v);
        pmb_loc_req_t w;
        w = ~v;
        w.wr = 1'b0;
        w.rd = 1'b0;
        w.ext_ld = 1'b0;
        @(posedge clk);
        loc <= v;
        @(posedge clk);
        loc <= w;
    endtask : lp

    task automatic irq_clr();
        chk({31'h0, lirq}, 32'h1);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
        chk({31'h0, lirq}, 32'h0);
    endtask : irq_clr

    // oldest note is matched against each answer as it appears
    always @(posedge clk) begin
        if (ack === 1'b1) begin
            if (note_q.size() == 0) begin
                chk(rdata, 32'hffff_ffff);
            end else begin
                note = note_q.pop_front();
                if (note[32]) chk(rdata, note[31:0]);
            end
        end
    end

    initial begin
        clk = 0; rst_n = 0; loc = '0; cfg = '0; clr = 0; om = 0; im = 0; pin_n = 1;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        acc(0, PMB_OFF_FILL_FLAGS, 4'hf, PMB_RST_FILL_FLAGS);
        acc(0, PMB_OFF_IRQ_CSR, 4'hf, PMB_RST_IRQ_CSR);
        acc(0, PMB_OFF_PT_CONFIG, 4'hf, PMB_RST_PT_CONFIG);
        // host touches mapped offsets only, nothing is promised elsewhere
        acc(0, PMB_OFF_SOFT_RST, 4'hf, 32'h0);
        $display("test reset values done");
        r = xs(); om = r;
        acc(1, PMB_OFF_OUT_MBOX, 4'hf, r);
        acc(0, PMB_OFF_OUT_MBOX, 4'hf, om);
        acc(0, PMB_OFF_FILL_FLAGS, 4'hf, 32'h0000_f000);
        cfg <= '{wr_en: 1'b1, wr_sel: 2'h1, rd_en: 1'b1, rd_sel: 2'h3};
        r = xs(); om[15:8] = r[15:8];
        acc(1, PMB_OFF_OUT_MBOX, 4'h2, r);
        acc(0, PMB_OFF_OUT_MBOX, 4'hf, om);
        irq_clr();
        acc(0, PMB_OFF_IN_MBOX, 4'hf, im);
        irq_clr();
        lp('{rd: 1'b1, rd_be: 4'hf, default: '0});
        acc(0, PMB_OFF_FILL_FLAGS, 4'hf, 32'h0);
        $display("test outgoing mailbox done");
        // add-on pin low with its enable set: level shows in bit 22 and reaches bit 23 and the host line
        c = PMB_RST_IRQ_CSR | (32'h1 << PMB_IRQ_ADDON_EN);
        pin_n <= 1'b0;
        acc(1, PMB_OFF_IRQ_CSR, 4'hf, c);
        acc(0, PMB_OFF_IRQ_CSR, 4'hf, c | 32'h00c0_0000);
        chk({31'h0, hirq}, 32'h1);
        pin_n <= 1'b1;
        acc(1, PMB_OFF_IRQ_CSR, 4'hf, PMB_RST_IRQ_CSR);
        acc(0, PMB_OFF_IRQ_CSR, 4'hf, PMB_RST_IRQ_CSR);
        chk({31'h0, hirq}, 32'h0);
        $display("test add-on pin done");
        for (i = 0; i < 4; i++) begin
            c = PMB_RST_IRQ_CSR | (32'h1 << PMB_IRQ_IN_EN) | (32'h1 << PMB_IRQ_OUT_EN)
                | (32'(i) << PMB_IRQ_IN_SEL) | (32'(i) << PMB_IRQ_OUT_SEL);
            acc(1, PMB_OFF_IRQ_CSR, 4'hf, c);
            r = xs(); im[8*i +: 8] = r[8*i +: 8];
            lp('{wr: 1'b1, wr_be: 4'h1 << i, wdata: r, rd: 1'b1, rd_be: 4'h1 << i, default: '0});
            acc(0, PMB_OFF_IRQ_CSR, 4'hf, c | 32'h0083_0000);
            chk({31'h0, hirq}, 32'h1);
            acc(1, PMB_OFF_IRQ_CSR, 4'hf, c | 32'h0001_0000);
            acc(0, PMB_OFF_IRQ_CSR, 4'hf, c | 32'h0082_0000);
            acc(1, PMB_OFF_IRQ_CSR, 4'hf, c | 32'h0002_0000);
            acc(0, PMB_OFF_IRQ_CSR, 4'hf, c);
            chk({31'h0, hirq}, 32'h0);
            acc(0, PMB_OFF_FILL_FLAGS, 4'hf, 32'h1 << (28 + i));
            acc(1, PMB_OFF_IN_MBOX, 4'hf, xs());
            acc(1, PMB_OFF_FILL_FLAGS, 4'hf, xs());
            acc(0, PMB_OFF_IN_MBOX, 4'hf, im);
            acc(0, PMB_OFF_FILL_FLAGS, 4'hf, 32'h0);
        end
        $display("test mailbox interrupts done");
        r = xs(); im[31:24] = r[7:0];
        lp('{ext_ld: 1'b1, ext_byte: r[7:0], default: '0});
        acc(0, PMB_OFF_FILL_FLAGS, 4'hf, 32'h8000_0000);
        acc(0, PMB_OFF_IN_MBOX, 4'hf, im);
        fork
            acc(1, PMB_OFF_OUT_MBOX, 4'h1, xs());
            lp('{rd: 1'b1, rd_be: 4'h1, default: '0});
        join
        acc(0, PMB_OFF_FILL_FLAGS, 4'hf, 32'h0000_1000);
        // soft reset: bit 27 empties every fill flag, bit 24 drives the add-on reset
        acc(1, PMB_OFF_SOFT_RST, 4'h8, 32'h0900_0000);
        acc(0, PMB_OFF_FILL_FLAGS, 4'hf, 32'h0);
        acc(0, PMB_OFF_SOFT_RST, 4'hf, 32'h0100_0000);
        chk({31'h0, arst}, 32'h1);
        $display("test byte load and collision done");
        stop_test();
    end
endmodule : pmb_mailbox_regs_tb_top

`default_nettype wire
